/* File: logic/crfc_regs.vh */
// Constants of the CPU register and condition flag core
`ifndef CRFC_REGS_VH
`define CRFC_REGS_VH

// ----------------------------------------------------------------
// Condition flag bit positions
// ----------------------------------------------------------------
`define CRFC_FLAG_I 7
`define CRFC_FLAG_U1 6
`define CRFC_FLAG_H 5
`define CRFC_FLAG_U0 4
`define CRFC_FLAG_N 3
`define CRFC_FLAG_Z 2
`define CRFC_FLAG_V 1
`define CRFC_FLAG_C 0
`define CRFC_FLAG_I_RESET 1'b1

// ----------------------------------------------------------------
// Register file layout
// ----------------------------------------------------------------
`define CRFC_SP_INDEX 3'h7
`define CRFC_SEL_LOW_BIT 3
`define CRFC_WORD_STEP 16'h0002

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CRFC_SYS_NS 10
`define CRFC_STATE_NS 100
`define CRFC_ALU_NS 200
`define CRFC_MULDIV_NS 1400

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CRFC_OP_MOV 5'h00
`define CRFC_OP_ADD 5'h01
`define CRFC_OP_SUB 5'h02
`define CRFC_OP_CMP 5'h03
`define CRFC_OP_NEG 5'h04
`define CRFC_OP_AND 5'h05
`define CRFC_OP_OR 5'h06
`define CRFC_OP_XOR 5'h07
`define CRFC_OP_SHL 5'h08
`define CRFC_OP_SHR 5'h09
`define CRFC_OP_ADRINC 5'h0A
`define CRFC_OP_ADRDEC 5'h0B
`define CRFC_OP_DAA 5'h0C
`define CRFC_OP_DAS 5'h0D
`define CRFC_OP_MUL 5'h0E
`define CRFC_OP_DIV 5'h0F
`define CRFC_OP_BLD 5'h10
`define CRFC_OP_BST 5'h11
`define CRFC_OP_BAND 5'h12
`define CRFC_OP_BOR 5'h13
`define CRFC_OP_BXOR 5'h14
`define CRFC_OP_BSET 5'h15
`define CRFC_OP_BCLR 5'h16
`define CRFC_OP_BNOT 5'h17
`define CRFC_OP_FLOAD 5'h18
`define CRFC_OP_FSTORE 5'h19
`define CRFC_OP_FAND 5'h1A
`define CRFC_OP_FOR 5'h1B
`define CRFC_OP_FXOR 5'h1C

`endif

/* File: logic/crfc_core.v */
// CPU general registers, program counter and condition flags
`timescale 1ns/1ps
`include "crfc_regs.vh"
// Summary of operation
// - Eight 16-bit registers; bytes of each separately readable and writable.
// - Register seven is the stack pointer, used implicitly by hardware.
// - Program counter is 16 bits; its lowest bit always reads zero.
// - Flag bit 7 masks interrupts; set by reset and interrupt entry.
// - Flag bits 6 and 4 are plain software-owned bits.
// - Half-carry records carry out of bit 3 (byte) or 11 (word).
// - Decimal adjust fixes packed BCD bytes using half-carry.
// - Negative flag copies result sign bit.
// - Zero flag set on zero result, cleared otherwise.
// - Overflow flag set on arithmetic overflow, cleared otherwise.
// - Carry: add/sub carry, shifted-out bit, bit accumulator.
// - Flags load, store, AND/OR/XOR immediate; branches test N Z V C.
// - Reset loads program counter from vector, sets mask, nothing else.
// - Word addresses and branch targets have their lowest bit forced zero.
// - Stack is word wide; flags pushed twice, pop keeps upper byte.
// - Bit operations act on one selected bit 0..7 of a byte.
// - All arithmetic and logic except address step accept bytes.
// - Word move/add/sub/compare, address step, multiply, divide use words.
// - Unified 64 kbyte space addressed by 16-bit addresses.
// - Add/sub take two states, multiply/divide fourteen, at 100 ns.
module crfc_core (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [15:0] i_reset_vector,
	// Operation request
	input wire i_op_valid,
	input wire [4:0] i_op_code,
	input wire i_op_word,
	input wire [3:0] i_op_dst,
	input wire [3:0] i_op_src,
	input wire i_op_use_imm,
	input wire [15:0] i_op_imm,
	input wire [2:0] i_op_bit,
	output wire o_op_ready,
	output reg o_op_done,
	// Register read port
	input wire [2:0] i_rd_sel,
	output reg [15:0] o_rd_word,
	// Program counter
	input wire i_pc_advance,
	input wire i_pc_load,
	input wire [15:0] i_pc_target,
	output reg [15:0] o_program_counter,
	// Flags and branch condition
	input wire [3:0] i_cond,
	output reg o_cond_true,
	output reg [7:0] o_condition_flags,
	// Interrupt entry
	input wire i_int_entry,
	// Stack
	input wire i_push_flags,
	input wire i_pop_flags,
	input wire [15:0] i_stack_rdata,
	output reg [15:0] o_stack_ptr,
	output reg o_stack_we,
	output reg [15:0] o_stack_addr,
	output reg [15:0] o_stack_wdata,
	// Data address
	input wire [15:0] i_ea,
	input wire i_ea_word,
	output reg [15:0] o_mem_addr
);

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam integer CYC_PER_STATE = `CRFC_STATE_NS / `CRFC_SYS_NS;
	localparam integer ALU_STATES = `CRFC_ALU_NS / `CRFC_STATE_NS;
	localparam integer MD_STATES = `CRFC_MULDIV_NS / `CRFC_STATE_NS;
	localparam integer DIV_LAST = CYC_PER_STATE - 1;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// General registers carry no reset: software must set them up
	reg [15:0] regs [0:7];
	reg busy;
	reg [3:0] div_cnt;
	reg [3:0] st_left;
	reg [4:0] op_code;
	reg op_word;
	reg [3:0] op_dst;
	reg [3:0] op_src;
	reg op_use_imm;
	reg [15:0] op_imm;
	reg [2:0] op_bit;

	wire state_tick;
	wire side_ok;
	wire [15:0] sp;
	wire [15:0] dst_w;
	wire [15:0] src_w;
	wire [7:0] dst_b;
	wire [7:0] src_b;
	wire [15:0] a16;
	wire [15:0] b16;
	wire [7:0] condition_flags;

	assign o_op_ready = ~busy;
	assign state_tick = busy & (div_cnt == DIV_LAST[3:0]);
	// Side-band writers of flags and SP act only while the execute unit is idle; while busy they are ignored
	assign side_ok = ~busy;
	assign sp = regs[`CRFC_SP_INDEX];
	assign condition_flags = o_condition_flags;
	assign dst_w = regs[op_dst[2:0]];
	assign src_w = regs[op_src[2:0]];
	assign dst_b = op_dst[`CRFC_SEL_LOW_BIT] ? dst_w[7:0] : dst_w[15:8];
	assign src_b = op_src[`CRFC_SEL_LOW_BIT] ? src_w[7:0] : src_w[15:8];
	assign a16 = op_word ? dst_w : {8'h00, dst_b};
	assign b16 = op_use_imm ? (op_word ? op_imm : {8'h00, op_imm[7:0]}) :
		(op_word ? src_w : {8'h00, src_b});

	// ----------------------------------------------------------------
	// Execute datapath
	// ----------------------------------------------------------------
	reg [15:0] x;
	reg [15:0] y;
	reg [16:0] sum;
	reg [16:0] dif;
	reg [4:0] hs4;
	reg [12:0] hs12;
	reg [15:0] res;
	reg [15:0] quot;
	reg [15:0] remd;
	reg [7:0] nccr;
	reg wr_en;
	reg wr_word;
	reg set_nz;
	reg rmsb;
	reg xmsb;
	reg ymsb;
	reg bitv;
	reg lo_adj;
	reg hi_adj;

	always @*
	begin
		x = a16;
		y = b16;
		if (op_code == `CRFC_OP_NEG)
		begin
			x = 16'h0000;
			y = a16;
		end
		sum = {1'b0, x} + {1'b0, y};
		dif = {1'b0, x} - {1'b0, y};
		hs4 = 5'h00;
		hs12 = 13'h0000;
		res = a16;
		nccr = condition_flags;
		wr_en = 1'b0;
		wr_word = op_word;
		set_nz = 1'b0;
		rmsb = 1'b0;
		xmsb = op_word ? x[15] : x[7];
		ymsb = op_word ? y[15] : y[7];
		bitv = dst_b[op_bit];
		lo_adj = 1'b0;
		hi_adj = 1'b0;
		quot = 16'h0000;
		remd = 16'h0000;
		case (op_code)
		`CRFC_OP_MOV:
		begin
			res = b16;
			wr_en = 1'b1;
			set_nz = 1'b1;
			nccr[`CRFC_FLAG_V] = 1'b0;
		end
		`CRFC_OP_ADD:
		begin
			res = sum[15:0];
			wr_en = 1'b1;
			set_nz = 1'b1;
			hs4 = {1'b0, x[3:0]} + {1'b0, y[3:0]};
			hs12 = {1'b0, x[11:0]} + {1'b0, y[11:0]};
			nccr[`CRFC_FLAG_H] = op_word ? hs12[12] : hs4[4];
			nccr[`CRFC_FLAG_C] = op_word ? sum[16] : sum[8];
			rmsb = op_word ? sum[15] : sum[7];
			nccr[`CRFC_FLAG_V] = (xmsb == ymsb) & (rmsb != xmsb);
		end
		`CRFC_OP_SUB, `CRFC_OP_CMP, `CRFC_OP_NEG:
		begin
			res = dif[15:0];
			wr_en = (op_code != `CRFC_OP_CMP);
			set_nz = 1'b1;
			nccr[`CRFC_FLAG_H] = op_word ? (x[11:0] < y[11:0]) :
				(x[3:0] < y[3:0]);
			nccr[`CRFC_FLAG_C] = (x < y);
			rmsb = op_word ? dif[15] : dif[7];
			nccr[`CRFC_FLAG_V] = (xmsb != ymsb) & (rmsb != xmsb);
		end
		`CRFC_OP_AND, `CRFC_OP_OR, `CRFC_OP_XOR:
		begin
			res = (op_code == `CRFC_OP_AND) ? (a16 & b16) :
				(op_code == `CRFC_OP_OR) ? (a16 | b16) : (a16 ^ b16);
			wr_en = 1'b1;
			set_nz = 1'b1;
			nccr[`CRFC_FLAG_V] = 1'b0;
		end
		`CRFC_OP_SHL:
		begin
			res = {a16[14:0], 1'b0};
			wr_en = 1'b1;
			set_nz = 1'b1;
			nccr[`CRFC_FLAG_C] = op_word ? a16[15] : a16[7];
			nccr[`CRFC_FLAG_V] = 1'b0;
		end
		`CRFC_OP_SHR:
		begin
			res = {1'b0, a16[15:1]};
			wr_en = 1'b1;
			set_nz = 1'b1;
			nccr[`CRFC_FLAG_C] = a16[0];
			nccr[`CRFC_FLAG_V] = 1'b0;
		end
		`CRFC_OP_ADRINC, `CRFC_OP_ADRDEC:
		begin
			// Address step is word only and leaves every flag alone
			res = (op_code == `CRFC_OP_ADRINC) ?
				dst_w + (op_imm[1] ? 16'h0002 : 16'h0001) :
				dst_w - (op_imm[1] ? 16'h0002 : 16'h0001);
			wr_en = 1'b1;
			wr_word = 1'b1;
		end
		`CRFC_OP_DAA:
		begin
			lo_adj = condition_flags[`CRFC_FLAG_H] | (dst_b[3:0] > 4'h9);
			hi_adj = condition_flags[`CRFC_FLAG_C] | (dst_b > 8'h99);
			res = {8'h00, dst_b + (hi_adj ? 8'h60 : 8'h00) +
				(lo_adj ? 8'h06 : 8'h00)};
			wr_en = 1'b1;
			wr_word = 1'b0;
			set_nz = 1'b1;
			nccr[`CRFC_FLAG_C] = hi_adj;
		end
		`CRFC_OP_DAS:
		begin
			res = {8'h00, dst_b - (condition_flags[`CRFC_FLAG_C] ? 8'h60 : 8'h00) -
				(condition_flags[`CRFC_FLAG_H] ? 8'h06 : 8'h00)};
			wr_en = 1'b1;
			wr_word = 1'b0;
			set_nz = 1'b1;
		end
		`CRFC_OP_MUL:
		begin
			res = {8'h00, dst_w[7:0]} * {8'h00, b16[7:0]};
			wr_en = 1'b1;
			wr_word = 1'b1;
		end
		`CRFC_OP_DIV:
		begin
			// Divide by zero leaves the destination as it was
			if (b16[7:0] != 8'h00)
			begin
				quot = dst_w / {8'h00, b16[7:0]};
				remd = dst_w % {8'h00, b16[7:0]};
				res = {remd[7:0], quot[7:0]};
				wr_en = 1'b1;
			end
			wr_word = 1'b1;
			nccr[`CRFC_FLAG_N] = b16[7];
			nccr[`CRFC_FLAG_Z] = (b16[7:0] == 8'h00);
		end
		`CRFC_OP_BLD, `CRFC_OP_BAND, `CRFC_OP_BOR, `CRFC_OP_BXOR:
		begin
			// Carry acts as a one-bit accumulator
			case (op_code)
			`CRFC_OP_BLD: nccr[`CRFC_FLAG_C] = bitv;
			`CRFC_OP_BAND: nccr[`CRFC_FLAG_C] = condition_flags[`CRFC_FLAG_C] & bitv;
			`CRFC_OP_BOR: nccr[`CRFC_FLAG_C] = condition_flags[`CRFC_FLAG_C] | bitv;
			default: nccr[`CRFC_FLAG_C] = condition_flags[`CRFC_FLAG_C] ^ bitv;
			endcase
		end
		`CRFC_OP_BST, `CRFC_OP_BSET, `CRFC_OP_BCLR, `CRFC_OP_BNOT:
		begin
			res = {8'h00, dst_b};
			res[op_bit] = (op_code == `CRFC_OP_BST) ? condition_flags[`CRFC_FLAG_C] :
				(op_code == `CRFC_OP_BSET) ? 1'b1 :
				(op_code == `CRFC_OP_BCLR) ? 1'b0 : ~bitv;
			wr_en = 1'b1;
			wr_word = 1'b0;
		end
		`CRFC_OP_FLOAD: nccr = b16[7:0];
		`CRFC_OP_FSTORE:
		begin
			res = {8'h00, condition_flags};
			wr_en = 1'b1;
			wr_word = 1'b0;
		end
		`CRFC_OP_FAND: nccr = condition_flags & op_imm[7:0];
		`CRFC_OP_FOR: nccr = condition_flags | op_imm[7:0];
		`CRFC_OP_FXOR: nccr = condition_flags ^ op_imm[7:0];
		default: nccr = condition_flags;
		endcase
		if (set_nz)
		begin
			nccr[`CRFC_FLAG_N] = wr_word ? res[15] : res[7];
			nccr[`CRFC_FLAG_Z] = wr_word ? (res == 16'h0000) :
				(res[7:0] == 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// Sequencing, register file and flags
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys)
	begin
		o_op_done <= 1'b0;
		o_stack_we <= 1'b0;
		if (!i_resetn)
		begin
			busy <= 1'b0;
			div_cnt <= 4'h0;
			st_left <= 4'h0;
			op_code <= `CRFC_OP_MOV;
			op_word <= 1'b0;
			op_dst <= 4'h0;
			op_src <= 4'h0;
			op_use_imm <= 1'b0;
			op_imm <= 16'h0000;
			op_bit <= 3'h0;
			o_stack_addr <= 16'h0000;
			o_stack_wdata <= 16'h0000;
			o_condition_flags[`CRFC_FLAG_I] <= `CRFC_FLAG_I_RESET;
		end
		else
		begin
			if (i_op_valid && !busy)
			begin
				busy <= 1'b1;
				div_cnt <= 4'h0;
				st_left <= (i_op_code == `CRFC_OP_MUL ||
					i_op_code == `CRFC_OP_DIV) ? MD_STATES[3:0] :
					ALU_STATES[3:0];
				op_code <= i_op_code;
				op_word <= i_op_word;
				op_dst <= i_op_dst;
				op_src <= i_op_src;
				op_use_imm <= i_op_use_imm;
				op_imm <= i_op_imm;
				op_bit <= i_op_bit;
			end
			else if (busy)
			begin
				div_cnt <= state_tick ? 4'h0 : div_cnt + 4'h1;
				if (state_tick)
					st_left <= st_left - 4'h1;
				if (state_tick && st_left == 4'h1)
				begin
					busy <= 1'b0;
					o_op_done <= 1'b1;
					o_condition_flags <= nccr;
					if (wr_en && wr_word)
						regs[op_dst[2:0]] <= res;
					else if (wr_en && op_dst[`CRFC_SEL_LOW_BIT])
						regs[op_dst[2:0]][7:0] <= res[7:0];
					else if (wr_en)
						regs[op_dst[2:0]][15:8] <= res[7:0];
				end
			end
			if (side_ok && i_push_flags)
			begin
				regs[`CRFC_SP_INDEX] <= sp - `CRFC_WORD_STEP;
				o_stack_addr <= {sp[15:1] - 15'h0001, 1'b0};
				o_stack_wdata <= {condition_flags, condition_flags};
				o_stack_we <= 1'b1;
			end
			else if (side_ok && i_pop_flags)
			begin
				regs[`CRFC_SP_INDEX] <= sp + `CRFC_WORD_STEP;
				o_condition_flags <= i_stack_rdata[15:8];
			end
			// Interrupt entry masks even over a same-cycle flag pop; while an operation is busy it is ignored
			if (side_ok && i_int_entry)
				o_condition_flags[`CRFC_FLAG_I] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Program counter, addresses and read port
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_program_counter <= {i_reset_vector[15:1], 1'b0};
			o_cond_true <= 1'b0;
			o_mem_addr <= 16'h0000;
			o_rd_word <= 16'h0000;
			o_stack_ptr <= 16'h0000;
		end
		else
		begin
			if (i_pc_load)
				o_program_counter <= {i_pc_target[15:1], 1'b0};
			else if (i_pc_advance)
				o_program_counter <= {o_program_counter[15:1] + 15'h0001,
					1'b0};
			o_mem_addr <= i_ea_word ? {i_ea[15:1], 1'b0} : i_ea;
			o_rd_word <= regs[i_rd_sel];
			o_stack_ptr <= {sp[15:1], 1'b0};
			case (i_cond)
			4'h0: o_cond_true <= 1'b1;
			4'h1: o_cond_true <= 1'b0;
			4'h2: o_cond_true <= ~(condition_flags[`CRFC_FLAG_C] | condition_flags[`CRFC_FLAG_Z]);
			4'h3: o_cond_true <= condition_flags[`CRFC_FLAG_C] | condition_flags[`CRFC_FLAG_Z];
			4'h4: o_cond_true <= ~condition_flags[`CRFC_FLAG_C];
			4'h5: o_cond_true <= condition_flags[`CRFC_FLAG_C];
			4'h6: o_cond_true <= ~condition_flags[`CRFC_FLAG_Z];
			4'h7: o_cond_true <= condition_flags[`CRFC_FLAG_Z];
			4'h8: o_cond_true <= ~condition_flags[`CRFC_FLAG_V];
			4'h9: o_cond_true <= condition_flags[`CRFC_FLAG_V];
			4'hA: o_cond_true <= ~condition_flags[`CRFC_FLAG_N];
			4'hB: o_cond_true <= condition_flags[`CRFC_FLAG_N];
			4'hC: o_cond_true <= ~(condition_flags[`CRFC_FLAG_N] ^ condition_flags[`CRFC_FLAG_V]);
			4'hD: o_cond_true <= condition_flags[`CRFC_FLAG_N] ^ condition_flags[`CRFC_FLAG_V];
			4'hE: o_cond_true <= ~(condition_flags[`CRFC_FLAG_Z] |
				(condition_flags[`CRFC_FLAG_N] ^ condition_flags[`CRFC_FLAG_V]));
			default: o_cond_true <= condition_flags[`CRFC_FLAG_Z] |
				(condition_flags[`CRFC_FLAG_N] ^ condition_flags[`CRFC_FLAG_V]);
			endcase
		end
	end

endmodule // crfc_core

/* File: tb/crfc_core_properties.sv */
// Port property checker of the register and flag core
`timescale 1ns/1ps
`include "crfc_regs.vh"
module crfc_core_properties (
	// Clock, reset and operation handshake
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [15:0] i_reset_vector,
	input wire i_op_valid,
	input wire [4:0] i_op_code,
	input wire o_op_ready,
	input wire o_op_done,
	// Counter, flags, stack and address
	input wire i_pc_advance,
	input wire i_pc_load,
	input wire [15:0] i_pc_target,
	input wire [15:0] o_program_counter,
	input wire [3:0] i_cond,
	input wire o_cond_true,
	input wire [7:0] o_condition_flags,
	input wire i_int_entry,
	input wire i_push_flags,
	input wire i_pop_flags,
	input wire [15:0] i_stack_rdata,
	input wire o_stack_we,
	input wire [15:0] o_stack_addr,
	input wire [15:0] o_stack_wdata,
	input wire [15:0] i_ea,
	input wire i_ea_word,
	input wire [15:0] o_mem_addr
);
	wire take = i_op_valid && o_op_ready;
	wire slow = i_op_code == `CRFC_OP_MUL || i_op_code == `CRFC_OP_DIV;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	// Reset is the cause here, so it must not also disable the check
	reset_state_a: assert property (disable iff (1'b0)
		!i_resetn |=> o_condition_flags[7] &&
		o_program_counter == ($past(i_reset_vector) & 16'hFFFE))
		else $error("reset state wrong");
	pc_step_a: assert property (i_pc_advance && !i_pc_load |=>
		o_program_counter == $past(o_program_counter) + 16'h0002)
		else $error("pc step wrong");
	pc_load_a: assert property (i_pc_load |=>
		o_program_counter == ($past(i_pc_target) & 16'hFFFE))
		else $error("pc load wrong");
	ea_align_a: assert property (i_ea_word |=>
		o_mem_addr == ($past(i_ea) & 16'hFFFE))
		else $error("word address wrong");
	int_mask_a: assert property (i_int_entry && o_op_ready |=>
		o_condition_flags[7]) else $error("mask not set");
	push_word_a: assert property (i_push_flags && o_op_ready |=>
		o_stack_we && !o_stack_addr[0] &&
		o_stack_wdata == {2{$past(o_condition_flags)}})
		else $error("flag push wrong");
	pop_high_a: assert property (i_pop_flags && o_op_ready &&
		!i_push_flags && !i_int_entry |=>
		o_condition_flags == $past(i_stack_rdata[15:8]))
		else $error("flag pop wrong");
	op_busy_a: assert property (take |=>
		(!o_op_ready && !o_op_done) [*8]) else $error("busy too short");
	short_lat_a: assert property (take && !slow |->
		##[20:21] o_op_done) else $error("short operation late");
	long_lat_a: assert property (take && slow |->
		##[140:141] o_op_done) else $error("long operation late");
	cond_eq_a: assert property (i_cond == 4'h7 |=>
		o_cond_true == $past(o_condition_flags[2]))
		else $error("equal condition wrong");
endmodule // crfc_core_properties

bind crfc_core crfc_core_properties crfc_core_properties_i (
	.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
	.i_reset_vector(i_reset_vector), .i_op_valid(i_op_valid),
	.i_op_code(i_op_code), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
	.i_pc_advance(i_pc_advance), .i_pc_load(i_pc_load),
	.i_pc_target(i_pc_target), .o_program_counter(o_program_counter),
	.i_cond(i_cond), .o_cond_true(o_cond_true),
	.o_condition_flags(o_condition_flags), .i_int_entry(i_int_entry),
	.i_push_flags(i_push_flags), .i_pop_flags(i_pop_flags),
	.i_stack_rdata(i_stack_rdata), .o_stack_we(o_stack_we),
	.o_stack_addr(o_stack_addr), .o_stack_wdata(o_stack_wdata),
	.i_ea(i_ea), .i_ea_word(i_ea_word), .o_mem_addr(o_mem_addr)
);

/* File: tb/crfc_stack_mem.sv */
// Word-wide stack memory model facing the core
`timescale 1ns/1ps
module crfc_stack_mem (
	// Clock
	input wire i_clk_sys,
	// Stack side
	input wire i_we,
	input wire [15:0] i_addr,
	input wire [15:0] i_wdata,
	input wire [15:0] i_rd_addr,
	output wire [15:0] o_rdata
);
	logic [15:0] mem [0:255];
	// Address bit 0 dropped: the stack only holds whole words
	always @(posedge i_clk_sys)
		if (i_we)
			mem[i_addr[8:1]] <= i_wdata;
	assign o_rdata = mem[i_rd_addr[8:1]];
endmodule // crfc_stack_mem

/* File: tb/crfc_core_bench.sv */
// Self-checking bench of the register and flag core
`timescale 1ns/1ps
`include "crfc_regs.vh"
module crfc_core_bench;
	typedef struct {
		logic [15:0] rv, rm;
		logic [7:0] fv, fm;
	} crfc_note_t;
	logic i_clk_sys, i_resetn, i_op_valid, i_op_word, i_op_use_imm;
	logic i_pc_advance, i_pc_load, i_int_entry, i_push_flags, i_pop_flags;
	logic i_ea_word, s, lo;
	logic [15:0] i_reset_vector, i_op_imm, i_pc_target, i_ea, w, r;
	logic [4:0] i_op_code;
	logic [3:0] i_op_dst, i_op_src, i_cond;
	logic [2:0] i_op_bit, i_rd_sel;
	logic [7:0] a, b;
	wire o_op_ready, o_op_done, o_cond_true, o_stack_we;
	wire [15:0] o_rd_word, o_program_counter, o_stack_ptr, o_stack_addr;
	wire [15:0] o_stack_wdata, o_mem_addr, i_stack_rdata;
	wire [7:0] o_condition_flags;
	int mismatches = 0;
	int checks = 0;
	int i;
	crfc_note_t notes[$];

	crfc_core crfc_core_i (
		.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_reset_vector(i_reset_vector), .i_op_valid(i_op_valid),
		.i_op_code(i_op_code), .i_op_word(i_op_word), .i_op_dst(i_op_dst),
		.i_op_src(i_op_src), .i_op_use_imm(i_op_use_imm),
		.i_op_imm(i_op_imm), .i_op_bit(i_op_bit), .o_op_ready(o_op_ready),
		.o_op_done(o_op_done), .i_rd_sel(i_rd_sel), .o_rd_word(o_rd_word),
		.i_pc_advance(i_pc_advance), .i_pc_load(i_pc_load),
		.i_pc_target(i_pc_target), .o_program_counter(o_program_counter),
		.i_cond(i_cond), .o_cond_true(o_cond_true),
		.o_condition_flags(o_condition_flags), .i_int_entry(i_int_entry),
		.i_push_flags(i_push_flags), .i_pop_flags(i_pop_flags),
		.i_stack_rdata(i_stack_rdata), .o_stack_ptr(o_stack_ptr),
		.o_stack_we(o_stack_we), .o_stack_addr(o_stack_addr),
		.o_stack_wdata(o_stack_wdata), .i_ea(i_ea), .i_ea_word(i_ea_word),
		.o_mem_addr(o_mem_addr)
	);
	crfc_stack_mem crfc_stack_mem_i (
		.i_clk_sys(i_clk_sys), .i_we(o_stack_we), .i_addr(o_stack_addr),
		.i_wdata(o_stack_wdata), .i_rd_addr(o_stack_ptr),
		.o_rdata(i_stack_rdata)
	);

	task automatic cmp16(string what, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp8(string what, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic wait_ready();
		for (int k = 0; k < 300 && o_op_ready !== 1'b1; k++)
			@(posedge i_clk_sys);
		if (o_op_ready !== 1'b1)
		begin
			mismatches++;
			wrap_up();
		end
	endtask
	// Holds the request until the edge that takes it, notes the outcome
	task automatic op(logic [4:0] c, logic wd, logic [3:0] d,
		logic [3:0] sr, logic u, logic [15:0] im, logic [15:0] rv,
		logic [15:0] rm, logic [7:0] fv, logic [7:0] fm);
		notes.push_back('{rv, rm, fv, fm});
		{i_op_code, i_op_word, i_op_dst, i_op_src} <= {c, wd, d, sr};
		{i_op_use_imm, i_op_imm, i_rd_sel} <= {u, im, d[2:0]};
		i_op_valid <= 1'b1;
		tick(1);
		wait_ready();
		i_op_valid <= 1'b0;
		tick(1);
		wait_ready();
		tick(2);
	endtask
	function automatic logic [15:0] alu8(logic [7:0] x, y, logic sb);
		logic [8:0] t;
		logic h, v;
		t = sb ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
		h = sb ? x[3:0] < y[3:0] : {1'b0, x[3:0]} + {1'b0, y[3:0]} > 5'h0F;
		v = (sb ? x[7] != y[7] : x[7] == y[7]) && t[7] != x[7];
		return {2'h0, h, 1'b0, t[7], t[7:0] == 8'h00, v, t[8], t[7:0]};
	endfunction

	initial
	begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	// Register read port lags one cycle, so results are taken after done
	initial
	begin
		crfc_note_t n;
		forever
		begin
			@(posedge i_clk_sys);
			if (o_op_done === 1'b1)
			begin
				@(posedge i_clk_sys);
				if (notes.size() == 0)
					cmp8("note queue", 8'h01, 8'h00);
				n = notes.pop_front();
				cmp16("register", n.rv & n.rm, o_rd_word & n.rm);
				cmp8("flags", n.fv & n.fm, o_condition_flags & n.fm);
			end
		end
	end

	initial
	begin
		{i_resetn, i_op_valid, i_op_word, i_op_use_imm, i_pc_advance} = 5'h00;
		{i_pc_load, i_int_entry, i_push_flags, i_pop_flags, i_ea_word} = 5'h00;
		{i_op_code, i_op_dst, i_op_src, i_cond, i_op_bit, i_rd_sel} = 23'h0;
		{i_op_imm, i_pc_target, i_ea} = 48'h0;
		i_reset_vector = 16'h1235;
		void'($urandom(36126));
		tick(2);
		i_resetn <= 1'b1;
		cmp16("pc", 16'h1234, o_program_counter);
		cmp8("mask", 8'h80, o_condition_flags & 8'h80);
		i_pc_advance <= 1'b1;
		tick(1);
		i_pc_advance <= 1'b0;
		tick(1);
		cmp16("pc", 16'h1236, o_program_counter);
		{i_pc_load, i_pc_advance, i_pc_target} <= {2'b11, 16'hBEEF};
		tick(1);
		{i_pc_load, i_pc_advance, i_ea_word, i_ea} <= {3'b001, 16'h4321};
		tick(1);
		cmp16("pc", 16'hBEEE, o_program_counter);
		i_ea_word <= 1'b0;
		tick(1);
		cmp16("word address", 16'h4320, o_mem_addr);
		tick(1);
		cmp16("byte address", 16'h4321, o_mem_addr);
		$display("counter and address test done");
		op(`CRFC_OP_FLOAD, 0, 0, 0, 1, 16'h50, 0, 0, 8'h50, 8'hFF);
		op(`CRFC_OP_FOR, 0, 0, 0, 1, 16'h0F, 0, 0, 8'h5F, 8'hFF);
		op(`CRFC_OP_FAND, 0, 0, 0, 1, 16'hF0, 0, 0, 8'h50, 8'hFF);
		op(`CRFC_OP_FXOR, 0, 0, 0, 1, 16'hFF, 0, 0, 8'hAF, 8'hFF);
		for (i = 4; i < 8; i++)
		begin
			i_cond <= 4'(i);
			tick(2);
			cmp8("branch", {7'h0, i[0]}, {7'h0, o_cond_true});
		end
		op(`CRFC_OP_FLOAD, 0, 0, 0, 1, 16'h00, 0, 0, 8'h00, 8'hFF);
		i_int_entry <= 1'b1;
		tick(1);
		i_int_entry <= 1'b0;
		tick(1);
		cmp8("flags", 8'h80, o_condition_flags);
		$display("flag test done");
		op(`CRFC_OP_MOV, 1, 7, 0, 1, 16'h0FF0, 16'h0FF0, 16'hFFFF, 0, 0);
		cmp16("stack pointer", 16'h0FF0, o_stack_ptr);
		op(`CRFC_OP_FLOAD, 0, 0, 0, 1, 16'hD6, 0, 0, 8'hD6, 8'hFF);
		i_push_flags <= 1'b1;
		tick(1);
		i_push_flags <= 1'b0;
		tick(3);
		cmp16("stack pointer", 16'h0FEE, o_stack_ptr);
		op(`CRFC_OP_FLOAD, 0, 0, 0, 1, 16'h00, 0, 0, 8'h00, 8'hFF);
		i_pop_flags <= 1'b1;
		tick(1);
		i_pop_flags <= 1'b0;
		tick(2);
		cmp8("flags", 8'hD6, o_condition_flags);
		cmp16("stack pointer", 16'h0FF0, o_stack_ptr);
		$display("stack test done");
		for (i = 0; i < 8; i++)
		begin
			a = i == 0 ? 8'h08 : i == 1 ? 8'h00 : 8'($urandom);
			b = i == 0 ? 8'h08 : i == 1 ? 8'h01 : 8'($urandom);
			s = i == 1 ? 1'b1 : 1'($urandom);
			{w, lo} = {16'($urandom), i[0]};
			if (lo)
				w[7:0] = a;
			else
				w[15:8] = a;
			op(`CRFC_OP_MOV, 1, 3, 0, 1, w, w, 16'hFFFF, 0, 0);
			r = alu8(a, b, s);
			w = lo ? {w[15:8], r[7:0]} : {r[7:0], w[7:0]};
			op(s ? `CRFC_OP_SUB : `CRFC_OP_ADD, 0, {lo, 3'h3}, 0, 1, {8'h0, b},
				w, 16'hFFFF, r[15:8], 8'h2F);
		end
		op(`CRFC_OP_MOV, 1, 1, 0, 1, 16'h7800, 16'h7800, 16'hFFFF, 0, 0);
		op(`CRFC_OP_MOV, 1, 2, 0, 1, 16'h0800, 16'h0800, 16'hFFFF, 0, 0);
		op(`CRFC_OP_ADD, 1, 1, 2, 0, 0, 16'h8000, 16'hFFFF, 8'h2A, 8'h2F);
		op(`CRFC_OP_MUL, 0, 7, 2, 0, 0, 16'h0780, 16'hFFFF,
			8'h2A, 8'h2F);
		op(`CRFC_OP_MOV, 1, 0, 0, 1, 16'h1208, 16'h1208, 16'hFFFF, 0, 0);
		i_op_bit <= 3'h7;
		op(`CRFC_OP_BSET, 0, 0, 0, 0, 0, 16'h9208, 16'hFFFF, 0, 0);
		i_op_bit <= 3'h3;
		op(`CRFC_OP_BCLR, 0, 8, 0, 0, 0, 16'h9200, 16'hFFFF, 0, 0);
		op(`CRFC_OP_MOV, 1, 4, 0, 1, 16'h1500, 16'h1500, 16'hFFFF,
			8'h00, 8'h00);
		op(`CRFC_OP_ADD, 0, 4, 0, 1, 16'h0027, 16'h3C00, 16'hFFFF,
			8'h00, 8'h2F);
		op(`CRFC_OP_DAA, 0, 4, 0, 0, 0, 16'h4200, 16'hFFFF,
			8'h00, 8'h2F);
		op(`CRFC_OP_SUB, 0, 4, 0, 1, 16'h0015, 16'h2D00, 16'hFFFF,
			8'h20, 8'h2F);
		op(`CRFC_OP_DAS, 0, 4, 0, 0, 0, 16'h2700, 16'hFFFF,
			8'h20, 8'h2F);
		op(`CRFC_OP_ADRINC, 1, 4, 0, 1, 16'h0002, 16'h2702, 16'hFFFF,
			8'h20, 8'h2F);
		op(`CRFC_OP_ADRDEC, 1, 4, 0, 1, 16'h0000, 16'h2701, 16'hFFFF,
			8'h20, 8'h2F);
		op(`CRFC_OP_CMP, 0, 4, 0, 1, 16'h0027, 16'h2701, 16'hFFFF,
			8'h04, 8'h2F);
		op(`CRFC_OP_MOV, 1, 4, 0, 1, 16'h0064, 16'h0064, 16'hFFFF,
			8'h00, 8'h00);
		op(`CRFC_OP_DIV, 0, 4, 0, 1, 16'h0007, 16'h020E, 16'hFFFF,
			8'h00, 8'h0C);
		i_op_bit <= 3'h1;
		op(`CRFC_OP_BLD, 0, 12, 0, 0, 0, 16'h020E, 16'hFFFF,
			8'h01, 8'h01);
		i_op_bit <= 3'h4;
		op(`CRFC_OP_BST, 0, 12, 0, 0, 0, 16'h021E, 16'hFFFF,
			8'h01, 8'h01);
		op(`CRFC_OP_FLOAD, 0, 0, 0, 1, 16'h5A, 0, 0, 8'h5A, 8'hFF);
		op(`CRFC_OP_FSTORE, 0, 12, 0, 0, 0, 16'h025A, 16'hFFFF,
			8'h5A, 8'hFF);
		$display("arithmetic and bit test done");
		cmp16("pending notes", 16'h0, 16'(notes.size()));
		wrap_up();
	end
endmodule // crfc_core_bench
